/* File: i2c_cfg_pkg.sv */
// Operation
// - bit-count field bits 7..5: code 000 means 8 bits, else code bits
// - acknowledge mode 1 adds one acknowledge clock pulse after data bits
// - acknowledge mode 0 gives pulses equal to selected data bits
// - divider exponent is code plus four; code 111 reserved; rate formula
// - reading clock-select bit 0 returns soft reset monitor, 0 during reset
// - after reset written bit 0 holds 0, monitor reads 1
package i2c_cfg_pkg;

  // ==========================================================
  // register map (byte offsets are index times four)
  // ==========================================================
  localparam logic [11:0] CFG_INDEX      = 12'h240;
  localparam logic [11:0] EN_INDEX       = 12'h247;
  localparam logic [13:0] CFG_ADDR       = {CFG_INDEX, 2'b00};
  localparam logic [13:0] EN_ADDR        = {EN_INDEX, 2'b00};
  localparam int          ADDR_W         = 14;

  // ==========================================================
  // field positions and reset values
  // ==========================================================
  localparam int          EN_BIT         = 7;
  localparam int          BC_LSB         = 5;
  localparam int          ACK_BIT        = 4;
  localparam int          SEL_LSB        = 0;
  localparam logic [7:0]  EN_RESET       = 8'h00;
  localparam logic [2:0]  BC_RESET       = 3'h0;
  localparam logic [2:0]  SEL_RESET      = 3'h0;
  localparam logic [3:0]  EXP_BASE       = 4'h4;
  localparam logic [2:0]  SEL_RESERVED   = 3'h7;
  localparam logic [5:0]  DIV_OFFSET     = 6'h24; // the 36 term
  localparam logic [3:0]  FULL_BITS      = 4'h8;

  // decoded configuration handed to the rest of the unit
  typedef struct packed {
    logic       enable;
    logic [3:0] data_bits;
    logic [3:0] scl_pulses;
    logic [3:0] div_exp;
    logic       sel_valid;
  } xfer_cfg_t;

endpackage

/* File: i2c_bus_ctrl_config_regs.sv */
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_ctrl_config_regs (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              cyc_i,
  input  wire logic                              stb_i,
  input  wire logic                              we_i,
  input  wire logic [i2c_cfg_pkg::ADDR_W-1:0]    adr_i,
  input  wire logic [31:0]                       dat_i,
  input  wire logic [3:0]                        sel_i,
  input  wire logic                              soft_reset_busy_i,
  output logic      [31:0]                       dat_o,
  output logic                                   ack_o,
  output logic                                   scl_tick_o,
  output i2c_cfg_pkg::xfer_cfg_t                 cfg_o
);
  import i2c_cfg_pkg::*;

  // ==========================================================
  // overview
  // ==========================================================
  // two byte-wide registers sit on the low byte of the data bus:
  // the unit enable word and the transfer configuration word.
  // every field is decoded here into cfg_o, so the shift engine
  // elsewhere never has to look at raw register codes.
  // the divider turns the written select code into one tick per
  // half scl period; the shift engine toggles scl on that tick.
  // the soft reset monitor shares bit 0 of the config word: a
  // read shows the monitor, never the written select bit, so a
  // read-modify-write by software would copy the monitor back
  // into the select code. full writes are the only safe access.

  // ==========================================================
  // state
  // ==========================================================
  logic       en_reg, en_next;
  logic [2:0] bc_reg, bc_next;
  logic       ack_mode_reg, ack_mode_next;
  logic [2:0] sel_reg, sel_next;
  logic       ack_reg, ack_next;
  logic [31:0] rd_reg, rd_next;
  logic       mon_reg, mon_next;
  logic [10:0] div_reg, div_next;
  logic       tick_reg, tick_next;
  xfer_cfg_t  cfg_reg, cfg_next;
  logic       req, hit_cfg, hit_en;
  logic [10:0] div_limit;

  // maps an exponent code to a full scl half period minus one
  function automatic logic [10:0] period_of(input logic [2:0] code);
    logic [10:0] p;
    p = 11'h000;
    p = (11'h001 << (code + EXP_BASE)) + {5'h00, DIV_OFFSET} - 11'h001;
    return p;
  endfunction

  // true when the bus address selects the given register
  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] r);
    return a == r;
  endfunction

  // ==========================================================
  // wishbone handshake
  // ==========================================================
  // one wait state: a request is taken while ack is low, ack
  // stands one cycle and drops even if stb is still held, so a
  // held strobe is taken again on the cycle after ack drops
  always_comb begin
    req      = cyc_i & stb_i & ~ack_reg;
    hit_cfg  = addr_is(adr_i, CFG_ADDR);
    hit_en   = addr_is(adr_i, EN_ADDR);
    ack_next = req;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
    end
  end

  // ==========================================================
  // unit enable register
  // ==========================================================
  // only the top bit has a flop; the low bits cannot be written
  always_comb begin
    en_next = en_reg;
    if (req && we_i && sel_i[0] && hit_en) begin
      en_next = dat_i[EN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_reg <= EN_RESET[EN_BIT];
    end else begin
      en_reg <= en_next;
    end
  end

  // ==========================================================
  // transfer configuration register
  // ==========================================================
  // a write takes on the edge the request is taken; bit 3 has no
  // storage and the low select bit is write-only
  always_comb begin
    bc_next       = bc_reg;
    ack_mode_next = ack_mode_reg;
    sel_next      = sel_reg;
    if (req && we_i && sel_i[0] && hit_cfg) begin
      bc_next       = dat_i[BC_LSB +: 3];
      ack_mode_next = dat_i[ACK_BIT];
      sel_next      = dat_i[SEL_LSB +: 3];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bc_reg       <= BC_RESET;
      ack_mode_reg <= 1'b0;
      sel_reg      <= SEL_RESET;
    end else begin
      bc_reg       <= bc_next;
      ack_mode_reg <= ack_mode_next;
      sel_reg      <= sel_next;
    end
  end

  // ==========================================================
  // soft reset monitor
  // ==========================================================
  // sampled every cycle; the one-cycle lag is harmless because a
  // soft reset lasts far longer than a bus read
  always_comb begin
    mon_next = ~soft_reset_busy_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mon_reg <= 1'b1;
    end else begin
      mon_reg <= mon_next;
    end
  end

  // ==========================================================
  // read data
  // ==========================================================
  // read data is registered so it stands exactly with ack; it is
  // held between reads, which costs nothing and keeps dat_o calm
  always_comb begin
    rd_next = rd_reg;
    if (req && !we_i) begin
      rd_next = 32'h0000_0000; // unmapped reads give zero
      if (hit_en) begin
        rd_next[EN_BIT] = en_reg;
      end
      if (hit_cfg) begin
        rd_next[BC_LSB +: 3] = bc_reg;
        rd_next[ACK_BIT]     = ack_mode_reg;
        rd_next[2:1]         = sel_reg[2:1];
        rd_next[0]           = mon_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_reg <= 32'h0000_0000;
    end else begin
      rd_reg <= rd_next;
    end
  end

  // ==========================================================
  // decoded configuration and scl rate divider
  // ==========================================================
  // one tick per scl half period: fsys/2/(2^n+36) as a full period
  always_comb begin
    div_limit           = period_of(sel_reg);
    cfg_next.enable     = en_reg;
    cfg_next.data_bits  = (bc_reg == 3'h0) ? FULL_BITS
                                           : {1'b0, bc_reg};
    cfg_next.scl_pulses = cfg_next.data_bits
                          + {3'h0, ack_mode_reg};
    cfg_next.div_exp    = {1'b0, sel_reg} + EXP_BASE;
    cfg_next.sel_valid  = sel_reg != SEL_RESERVED;
    div_next            = div_reg;
    tick_next           = 1'b0;
    // a disabled unit or reserved code keeps the divider idle
    if (!en_reg || !cfg_next.sel_valid) begin
      div_next = 11'h000;
    end else if (div_reg >= div_limit) begin
      div_next  = 11'h000;
      tick_next = 1'b1;
    end else begin
      div_next = div_reg + 11'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg  <= '0;
      div_reg  <= 11'h000;
      tick_reg <= 1'b0;
    end else begin
      cfg_reg  <= cfg_next;
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign dat_o      = rd_reg;
  assign ack_o      = ack_reg;
  assign scl_tick_o = tick_reg;
  assign cfg_o      = cfg_reg;

endmodule
`default_nettype wire

/* File: dummy_unused_marker.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: i2c_cfg_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// config register checks
module cfg_checker
  import i2c_cfg_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic              we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [31:0]       dat_i,
  input wire logic [3:0]        sel_i,
  input wire logic              soft_reset_busy_i,
  input wire logic [31:0]       dat_o,
  input wire logic              ack_o,
  input wire logic              scl_tick_o,
  input wire xfer_cfg_t         cfg_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // answered accesses; request still held while ack is high
  wire logic wr = ack_o & stb_i & we_i & sel_i[0];
  wire logic rd = ack_o & stb_i & !we_i;
  wire logic wrc = wr && adr_i == CFG_ADDR;
  wire logic [3:0] bits = dat_i[7:5] == 3'h0 ? 4'h8 : {1'b0, dat_i[7:5]};
  property p_bits; wrc |-> ##1 cfg_o.data_bits == $past(bits); endproperty
  a_bits: assert property (p_bits) else $error("bit count wrong");
  property p_ack; wrc |-> ##1
    cfg_o.scl_pulses == $past(bits) + $past(dat_i[4]); endproperty
  a_ack: assert property (p_ack) else $error("pulse count wrong");
  property p_exp; wrc && dat_i[2:0] != 3'h7 |-> ##1
    cfg_o.div_exp == $past(dat_i[2:0]) + 4'h4; endproperty
  a_exp: assert property (p_exp) else $error("divider wrong");
  // busy held three samples, so the monitor lag cannot matter
  property p_mon; rd && adr_i == CFG_ADDR && $stable(soft_reset_busy_i) &&
    $past(soft_reset_busy_i) == $past(soft_reset_busy_i, 2) |->
    dat_o[0] == !soft_reset_busy_i; endproperty
  a_mon: assert property (p_mon) else $error("monitor wrong");
  property p_rst; $fell(rst_i) |-> ##2 cfg_o.data_bits == 4'h8 &&
    cfg_o.div_exp == 4'h4; endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_enr; rd && adr_i == EN_ADDR |-> dat_o[31:8] == 24'h0 &&
    dat_o[6:0] == 7'h0; endproperty
  a_enr: assert property (p_enr) else $error("enable read wrong");
  property p_enw; wr && adr_i == EN_ADDR |-> ##1
    cfg_o.enable == $past(dat_i[7]); endproperty
  a_enw: assert property (p_enw) else $error("enable store wrong");
  // handshake: a taken request is answered next cycle, once
  sequence s_take; cyc_i && stb_i && !ack_o; endsequence
  property p_answer; s_take |=> ack_o; endproperty
  a_answer: assert property (p_answer) else $error("ack missing");
  property p_drop; ack_o |=> !ack_o; endproperty
  a_drop: assert property (p_drop) else $error("ack held too long");
endmodule
bind i2c_bus_ctrl_config_regs cfg_checker u_chk (.*);
`default_nettype wire

/* File: soft_reset_src.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// unit soft reset: busy for a fixed span after each request
module soft_reset_src #(parameter int SPAN = 6) (
  input  wire logic clk_i,
  input  wire logic go_i,
  output logic      busy_o
);
  int cnt = 0;
  // span outlasts a read so the monitor sees it
  always_ff @(posedge clk_i) begin
    if (go_i) cnt <= SPAN;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign busy_o = cnt > 0;
endmodule
`default_nettype wire

/* File: tb_i2c_bus_ctrl_config_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_bus_ctrl_config_regs;
  import i2c_cfg_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, go = 0;
  logic [ADDR_W-1:0] adr_i = 14'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic [3:0] sel_i = 4'h0;
  logic ack_o, scl_tick_o, busy;
  xfer_cfg_t cfg_o;
  int fails = 0, tests_run = 0, n;
  i2c_bus_ctrl_config_regs u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i),
    .sel_i(sel_i), .soft_reset_busy_i(busy), .dat_o(dat_o), .ack_o(ack_o),
    .scl_tick_o(scl_tick_o), .cfg_o(cfg_o));
  soft_reset_src u_src (.clk_i(clk_i), .go_i(go), .busy_o(busy));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic cycle; held until ack is sampled, then released
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hF};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, EN_ADDR, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, CFG_ADDR, 32'h0);
    chk(q, 32'h1);
    bus(1'b1, EN_ADDR, 32'hFF);
    bus(1'b0, EN_ADDR, 32'h0);
    chk(q, 32'h80);
    $display("test reset and enable done");
    for (n = 0; n < 8; n++) begin
      bus(1'b1, CFG_ADDR, {24'h0, n[2:0], n[0], 1'b0, n[2:0]});
      bus(1'b0, CFG_ADDR, 32'h0);
      chk(q, {24'h0, n[2:0], n[0], 1'b0, n[2:1], 1'b1});
      chk(cfg_o.scl_pulses, (n == 0 ? 8 : n) + n[0]);
      chk(cfg_o.sel_valid, n != 7);
      chk(cfg_o.data_bits, (n == 0 ? 8 : n));
      if (n != 7) chk(cfg_o.div_exp, n + 4);
    end
    $display("test codes done");
    bus(1'b1, CFG_ADDR, 32'h0);
    @(posedge clk_i iff scl_tick_o === 1'b1);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (scl_tick_o !== 1'b1);
    chk(n, 52);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    bus(1'b0, CFG_ADDR, 32'h0);
    chk(q[0], 0);
    bus(1'b1, EN_ADDR, 32'h0);
    @(posedge clk_i);
    chk(cfg_o.enable, 0);
    n = 0;
    repeat (120) begin
      @(posedge clk_i);
      if (scl_tick_o !== 1'b0) n++;
    end
    chk(n, 0);
    bus(1'b0, CFG_ADDR + 14'h4, 32'h0);
    chk(q, 32'h0);
    $display("test tick, monitor, unmapped done");
    end_sim();
  end
endmodule
`default_nettype wire
